// ---- hw/sdbp_ctrl.sv ----
`timescale 1ns/1ps
`include "sdbp_defs.svh"
module sdbp_ctrl
   import sdbp_pkg::*;
#(
   parameter int COL_W = 4,
   parameter int DQ_W = 16,
   parameter int WR_CYC = `SDBP_WR_CYC,
   parameter int RP_CYC = `SDBP_RP_CYC,
   parameter int RAS_CYC = `SDBP_RAS_CYC
) (
   input logic clk,
   input logic sys_rst,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic cs_n,
   input logic ras_n,
   input logic cas_n,
   input logic we_n,
   input logic addr_bit_ten,
   input logic [COL_W-1:0] col_addr,
   input logic bank_select_low,
   input logic bank_select_high,
   input logic [DQ_W/8-1:0] dqm,
   input logic [DQ_W-1:0] dq_in,
   output logic [DQ_W-1:0] dq_out,
   output logic [DQ_W/8-1:0] dq_oe
);
   import sdbp_pkg::*;
   localparam int NBY = DQ_W / 8;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   sdbp_cmd_t cmd;
   logic [1:0] bank_in;
   logic [3:0] bk_active;
   logic cmd_act, cmd_rd, cmd_wr, cmd_bst, cmd_pre, rd_ok, wr_ok;
   // deselected cycles fold onto an illegal code and do nothing
   assign cmd = sdbp_cmd_t'({cs_n, ras_n, cas_n, we_n});
   assign bank_in = {bank_select_high, bank_select_low};
   assign cmd_act = (cmd == SDBP_CMD_ACT);
   assign cmd_rd = (cmd == SDBP_CMD_RD);
   assign cmd_wr = (cmd == SDBP_CMD_WR);
   assign cmd_bst = (cmd == SDBP_CMD_BST);
   assign cmd_pre = (cmd == SDBP_CMD_PRE);
   // column access only to an open row
   assign rd_ok = cmd_rd && bk_active[bank_in];
   assign wr_ok = cmd_wr && bk_active[bank_in];

   // ----------------------------------------
   // configuration over apb
   // ----------------------------------------
   logic [`SDBP_CFG_W-1:0] cfg_r;
   logic [1:0] cfg_rl;
   logic [2:0] cfg_bl;
   logic cfg_wbm, bl_cont, wr_cont, ap_ok;
   logic [3:0] bl_len, wr_len;
   assign cfg_rl = cfg_r[`SDBP_CFG_RL_LSB +: 2];
   assign cfg_bl = cfg_r[`SDBP_CFG_BL_LSB +: 3];
   assign cfg_wbm = cfg_r[`SDBP_CFG_WBM_BIT];
   assign bl_cont = (cfg_bl == `SDBP_BL_CONT);
   assign bl_len = 4'h1 << cfg_bl[1:0];
   assign wr_len = cfg_wbm ? 4'h1 : bl_len;
   // single-write mode beats continuous for writes
   assign wr_cont = bl_cont && !cfg_wbm;
   assign ap_ok = addr_bit_ten && !bl_cont;

   // ----------------------------------------
   // write burst engine
   // ----------------------------------------
   logic wr_act_r, wr_ap_r, wr_cn_r;
   logic [1:0] wr_bank_r;
   logic [COL_W-1:0] wr_col_r;
   logic [3:0] wr_left_r;
   logic wr_stop, wr_go, wr_fin_old, wr_fin_new, mem_we;
   logic [COL_W+1:0] mem_wa;
   // any other column command or a precharge of this bank ends it
   assign wr_stop = cmd_rd || cmd_wr || cmd_bst
      || (cmd_pre && (addr_bit_ten || bank_in == wr_bank_r));
   assign wr_go = wr_act_r && !wr_stop;
   assign wr_fin_old = wr_act_r && (wr_stop || (!wr_cn_r && wr_left_r == 4'h1));
   assign wr_fin_new = wr_ok && wr_len == 4'h1;
   assign mem_we = wr_ok || wr_go;
   assign mem_wa = wr_ok ? {bank_in, col_addr} : {wr_bank_r, wr_col_r};

   // new write reloads, otherwise step the column
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wr_act_r <= 1'b0;
      else if (wr_ok)
      begin
         wr_act_r <= wr_cont || wr_len != 4'h1;
         wr_bank_r <= bank_in;
         wr_col_r <= COL_W'(col_addr + 1'b1);
         wr_left_r <= wr_len - 4'h1;
         wr_ap_r <= ap_ok;
         wr_cn_r <= wr_cont;
      end
      else if (wr_go)
      begin
         wr_act_r <= wr_cn_r || wr_left_r != 4'h1;
         wr_col_r <= COL_W'(wr_col_r + 1'b1);
         wr_left_r <= wr_left_r - 4'h1;
      end
      else
         wr_act_r <= 1'b0;
   end

   // ----------------------------------------
   // read burst engine
   // ----------------------------------------
   logic rd_act_r, rd_ap_r, rd_cn_r;
   logic [1:0] rd_bank_r;
   logic [COL_W-1:0] rd_col_r;
   logic [3:0] rd_left_r;
   logic rd_stop, rd_go, rd_fin_old, rd_fin_new, fetch;
   logic [COL_W+1:0] mem_ra;
   logic [DQ_W-1:0] mem_rd;
   // terminate is honoured only without auto precharge
   assign rd_stop = cmd_rd || cmd_wr || (cmd_bst && !rd_ap_r)
      || (cmd_pre && (addr_bit_ten || bank_in == rd_bank_r));
   assign rd_go = rd_act_r && !rd_stop;
   assign rd_fin_old = rd_act_r && (rd_stop || (!rd_cn_r && rd_left_r == 4'h1));
   assign rd_fin_new = rd_ok && bl_len == 4'h1 && !bl_cont;
   assign fetch = rd_ok || rd_go;
   assign mem_ra = rd_ok ? {bank_in, col_addr} : {rd_bank_r, rd_col_r};

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rd_act_r <= 1'b0;
      else if (rd_ok)
      begin
         rd_act_r <= bl_cont || bl_len != 4'h1;
         rd_bank_r <= bank_in;
         rd_col_r <= COL_W'(col_addr + 1'b1);
         rd_left_r <= bl_len - 4'h1;
         rd_ap_r <= ap_ok;
         rd_cn_r <= bl_cont;
      end
      else if (rd_go)
      begin
         rd_act_r <= rd_cn_r || rd_left_r != 4'h1;
         rd_col_r <= COL_W'(rd_col_r + 1'b1);
         rd_left_r <= rd_left_r - 4'h1;
      end
      else
         rd_act_r <= 1'b0;
   end

   sdbp_mem #(
      .AW(COL_W + 2),
      .DW(DQ_W)
   ) u_mem (
      .clk(clk),
      .wr_en(mem_we),
      .wr_addr(mem_wa),
      .wr_be(~dqm),
      .wr_data(dq_in),
      .rd_addr(mem_ra),
      .rd_data(mem_rd)
   );

   // ----------------------------------------
   // read data pipeline
   // ----------------------------------------
   logic fv_r, d1_v_r, d2_v_r, src_v;
   logic [DQ_W-1:0] d1_r, d2_r, src_d, dq_out_r;
   logic [NBY-1:0] dqm_d1_r, dqm_d2_r, dq_oe_r;
   // a registered write drops whatever read data is in flight
   assign src_v = (cfg_rl == `SDBP_RL_THREE) ? d2_v_r : d1_v_r;
   assign src_d = (cfg_rl == `SDBP_RL_THREE) ? d2_r : d1_r;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         fv_r <= 1'b0;
         d1_v_r <= 1'b0;
         d2_v_r <= 1'b0;
         dqm_d1_r <= '0;
         dqm_d2_r <= '0;
         dq_oe_r <= '0;
         dq_out_r <= '0;
      end
      else
      begin
         fv_r <= fetch;
         d1_v_r <= fv_r && !cmd_wr;
         d2_v_r <= d1_v_r && !cmd_wr;
         d1_r <= mem_rd;
         d2_r <= d1_r;
         dqm_d1_r <= dqm;
         dqm_d2_r <= dqm_d1_r;
         dq_oe_r <= (src_v && !cmd_wr) ? ~dqm_d2_r : '0;
         dq_out_r <= src_d;
      end
   end
   assign dq_out = dq_out_r;
   assign dq_oe = dq_oe_r;

   // ----------------------------------------
   // per-bank state and timers
   // ----------------------------------------
   sdbp_bk_state_t bk_state_r [4];
   sdbp_bk_state_t bk_state_nxt [4];
   logic [3:0] ap_fire;
   logic [7:0] stat_bk;
   for (genvar b = 0; b < 4; b++)
   begin : g_bank
      logic [3:0] ras_cnt_r, rp_cnt_r, wrec_r;
      logic apq_r, act_hit, pre_hit, rd_ap, wr_ap, ap_set, ras_ok;
      assign act_hit = cmd_act && bank_in == 2'(b);
      assign pre_hit = cmd_pre && (addr_bit_ten || bank_in == 2'(b));
      // read end or interruption by any column command
      assign rd_ap = (rd_fin_old && rd_ap_r && rd_bank_r == 2'(b))
         || (rd_fin_new && ap_ok && bank_in == 2'(b));
      // write end or interruption starts recovery
      assign wr_ap = (wr_fin_old && wr_ap_r && wr_bank_r == 2'(b))
         || (wr_fin_new && ap_ok && bank_in == 2'(b));
      assign ap_set = rd_ap || wrec_r == 4'h1;
      assign ras_ok = ras_cnt_r >= 4'(RAS_CYC - 1);
      assign ap_fire[b] = (apq_r || ap_set) && ras_ok
         && bk_state_r[b] == SDBP_BK_ACT;
      assign bk_active[b] = bk_state_r[b] == SDBP_BK_ACT;
      assign stat_bk[2*b +: 2] = bk_state_r[b];

      always_comb
      begin
         bk_state_nxt[b] = bk_state_r[b];
         unique case (bk_state_r[b])
            SDBP_BK_IDLE:
               if (act_hit)
                  bk_state_nxt[b] = SDBP_BK_ACT;
            SDBP_BK_ACT:
               if (pre_hit || ap_fire[b])
                  bk_state_nxt[b] = SDBP_BK_PRE;
            SDBP_BK_PRE:
               if (rp_cnt_r <= 4'h1)
                  bk_state_nxt[b] = SDBP_BK_IDLE;
            default:
               bk_state_nxt[b] = SDBP_BK_IDLE;
         endcase
      end

      // lock-out defers a request rather than dropping it
      always_ff @(posedge clk)
      begin
         if (sys_rst)
         begin
            bk_state_r[b] <= SDBP_BK_IDLE;
            ras_cnt_r <= '0;
            rp_cnt_r <= '0;
            wrec_r <= '0;
            apq_r <= 1'b0;
         end
         else
         begin
            bk_state_r[b] <= bk_state_nxt[b];
            ras_cnt_r <= act_hit ? 4'h0 : (ras_ok ? ras_cnt_r : ras_cnt_r + 4'h1);
            rp_cnt_r <= (bk_state_nxt[b] == SDBP_BK_PRE && bk_state_r[b] == SDBP_BK_ACT)
               ? 4'(RP_CYC) : (rp_cnt_r != 4'h0 ? rp_cnt_r - 4'h1 : 4'h0);
            wrec_r <= wr_ap ? 4'(WR_CYC) : (wrec_r != 4'h0 ? wrec_r - 4'h1 : 4'h0);
            apq_r <= (apq_r || ap_set) && !ap_fire[b]
               && bk_state_nxt[b] == SDBP_BK_ACT;
         end
      end

      a_ras_lockout: assert property (@(posedge clk) disable iff (sys_rst)
         ap_fire[b] |-> ras_cnt_r >= 4'(RAS_CYC - 1))
         else $error("auto precharge before row active time");
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   logic pready_r, pslverr_r, apb_acc, apb_done, sel_cfg, sel_stat;
   logic [31:0] prdata_r, rd_mux;
   assign apb_acc = psel && penable;
   assign apb_done = apb_acc && pready_r;
   assign sel_cfg = paddr == `SDBP_CFG_OFS;
   assign sel_stat = paddr == `SDBP_STAT_OFS;
   assign rd_mux = sel_cfg ? {26'h0, cfg_r}
      : (sel_stat ? {22'h0, wr_act_r, rd_act_r, stat_bk} : 32'h0);
   // one wait state, so data and error come from flops
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
         cfg_r <= `SDBP_CFG_RST;
      end
      else
      begin
         pready_r <= apb_acc && !pready_r;
         pslverr_r <= apb_acc && !pready_r && !sel_cfg && !sel_stat;
         prdata_r <= (apb_acc && !pready_r && !pwrite) ? rd_mux : 32'h0;
         if (apb_done && pwrite && sel_cfg)
            cfg_r <= pwdata[`SDBP_CFG_W-1:0];
      end
   end
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_mask_seen;
      dqm[0] ##2 1'b1;
   endsequence
   sequence s_cont_wrap;
      wr_act_r && wr_cn_r && wr_col_r == '1 && !wr_stop;
   endsequence

   a_wr_first: assert property (wr_ok |-> mem_we && mem_wa[COL_W-1:0] == col_addr)
      else $error("write data not taken with command");
   a_wr_idle: assert property (!wr_act_r && !cmd_wr |-> !mem_we)
      else $error("write after burst end");
   a_rd_ignore: assert property (cmd_rd |-> !mem_we)
      else $error("write data taken on read edge");
   a_bst_ignore: assert property (cmd_bst |-> !mem_we)
      else $error("write data taken on terminate edge");
   a_wr_wrap: assert property (s_cont_wrap |=> wr_col_r == '0)
      else $error("continuous write did not wrap");
   a_single_wr: assert property (wr_ok && cfg_wbm |=> !wr_act_r)
      else $error("single write mode ran a burst");
   a_pre_all: assert property (cmd_pre && addr_bit_ten |=> bk_active == 4'h0)
      else $error("precharge all left a bank open");
   a_ap_cont: assert property (rd_ok && bl_cont |=> !rd_ap_r)
      else $error("auto precharge armed in continuous mode");
   a_rd_mask: assert property (s_mask_seen |=> !dq_oe[0])
      else $error("masked read byte driven");
   a_wr_kill: assert property (cmd_wr |=> dq_oe == '0)
      else $error("read output after write registered");
endmodule

// ---- inc/sdbp_defs.svh ----
`ifndef SDBP_DEFS_SVH
`define SDBP_DEFS_SVH
// ----------------------------------------
// clock and timing figures
// ----------------------------------------
`define SDBP_CLK_NS 20
`define SDBP_TWR_NS 15
`define SDBP_TRP_NS 18
`define SDBP_ROW_ACTIVE_MIN_TIME_NS 42
// least times round up to whole cycles
`define SDBP_CYC_UP(ns) (((ns) + `SDBP_CLK_NS - 1) / `SDBP_CLK_NS)
`define SDBP_WR_CYC `SDBP_CYC_UP(`SDBP_TWR_NS)
`define SDBP_RP_CYC `SDBP_CYC_UP(`SDBP_TRP_NS)
`define SDBP_RAS_CYC `SDBP_CYC_UP(`SDBP_ROW_ACTIVE_MIN_TIME_NS)
// ----------------------------------------
// register map
// ----------------------------------------
`define SDBP_CFG_OFS 12'h000
`define SDBP_STAT_OFS 12'h004
`define SDBP_CFG_RL_LSB 0
`define SDBP_CFG_BL_LSB 2
`define SDBP_CFG_WBM_BIT 5
`define SDBP_CFG_W 6
`define SDBP_CFG_RST 6'h0a
`define SDBP_BL_CONT 3'h7
`define SDBP_RL_THREE 2'h3
`endif

// ---- inc/sdbp_pkg.sv ----
package sdbp_pkg;
   // per-bank row state
   typedef enum logic [1:0] {
      SDBP_BK_IDLE = 2'b00,
      SDBP_BK_ACT = 2'b01,
      SDBP_BK_PRE = 2'b10
   } sdbp_bk_state_t;
   // {select_n, row_n, col_n, write_n}
   typedef enum logic [3:0] {
      SDBP_CMD_ACT = 4'b0011,
      SDBP_CMD_RD = 4'b0101,
      SDBP_CMD_WR = 4'b0100,
      SDBP_CMD_BST = 4'b0110,
      SDBP_CMD_PRE = 4'b0010,
      SDBP_CMD_NOP = 4'b0111
   } sdbp_cmd_t;
endpackage

// ---- hw/sdbp_mem.sv ----
`timescale 1ns/1ps
// little array, byte-lane writes, registered read data
module sdbp_mem #(
   parameter int AW = 6,
   parameter int DW = 16
) (
   input logic clk,
   input logic wr_en,
   input logic [AW-1:0] wr_addr,
   input logic [DW/8-1:0] wr_be,
   input logic [DW-1:0] wr_data,
   input logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [2**AW];
   // one lane per byte so masked bytes keep old contents
   for (genvar i = 0; i < DW/8; i++)
   begin : g_lane
      always_ff @(posedge clk)
      begin
         if (wr_en && wr_be[i])
            mem[wr_addr][8*i +: 8] <= wr_data[8*i +: 8];
      end
   end
   always_ff @(posedge clk)
   begin
      rd_data <= mem[rd_addr];
   end
endmodule

// ---- verif/sdbp_mc_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// memory controller model: one command per edge
// ----------------------------------------
module sdbp_mc_model
   import sdbp_pkg::*;
(
   input wire logic clk,
   output logic [3:0] cmd,
   output logic ap,
   output logic [3:0] col,
   output logic [1:0] bk,
   output logic [1:0] dqm,
   output logic [15:0] dq
);
   import sdbp_pkg::*;
   int cyc = 0;
   logic [15:0] held = 16'h0000;
   // edge index, read before the edge's own update lands
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
   end
   // idle bus at time zero
   initial
   begin
      cmd = SDBP_CMD_NOP;
      ap = 1'b0;
      col = 4'h0;
      bk = 2'b00;
      dqm = 2'b00;
      dq = 16'hffff;
   end
   // drive after an edge, t returns the edge that samples it;
   // the period is 20 ns, so no byte mask is needed around a cut
   task automatic put(input logic [3:0] c, input logic [1:0] b, input logic [3:0] a,
      input logic p, input logic drv, input logic [15:0] d, input logic [1:0] m, output int t);
      @(posedge clk);
      t = cyc + 1;
      cmd <= c;
      bk <= b;
      col <= a;
      ap <= p;
      dqm <= m;
      // a released bus shows the inverse, not a stale copy
      if (drv)
      begin
         dq <= d;
         held = d;
      end
      else
      begin
         dq <= ~held;
      end
   endtask
endmodule

// ---- verif/test_sdbp_ctrl.sv ----
`timescale 1ns/1ps
module test_sdbp_ctrl;
   import sdbp_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] mc_cmd;
   logic mc_ap;
   logic [3:0] mc_col;
   logic [1:0] mc_bk;
   logic [1:0] dqm;
   logic [15:0] dq_in;
   logic [15:0] dq_out;
   logic [1:0] dq_oe;
   logic [15:0] mx [4][16];
   logic [15:0] qd [$];
   int qt [$];
   int cyc = 0;
   int n_mismatch = 0;
   int tests_run = 0;
   int rl = 2;
   int t;
   int t0;
   int t1;
   logic [31:0] rv;
   logic re;
   // ----------------------------------------
   // clock, parts, read monitor
   // ----------------------------------------
   always #10 clk = ~clk;
   sdbp_ctrl #(.WR_CYC(2), .RP_CYC(2), .RAS_CYC(8)) u_dut (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(mc_cmd[3]), .ras_n(mc_cmd[2]),
      .cas_n(mc_cmd[1]), .we_n(mc_cmd[0]), .addr_bit_ten(mc_ap), .col_addr(mc_col),
      .bank_select_low(mc_bk[0]), .bank_select_high(mc_bk[1]), .dqm(dqm), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe));
   sdbp_mc_model u_mc (.clk(clk), .cmd(mc_cmd), .ap(mc_ap), .col(mc_col), .bk(mc_bk),
      .dqm(dqm), .dq(dq_in));
   // a half-driven element is stored unknown so only an unknown expectation matches it
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (dq_oe !== 2'b00)
      begin
         qd.push_back(dq_oe === 2'b11 ? dq_out : 16'hxxxx);
         qt.push_back(cyc);
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] w);
      tests_run++;
      if (s !== w)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h want %h", $time, s, w);
      end
   endtask
   task automatic close_out;
      if (n_mismatch == 0 && tests_run > 0)
      begin
         $display("SIMULATION PASSED");
      end
      else
      begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      chk({31'h0, pready}, 32'h1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic st(input logic [7:0] w);
      apb(1'b0, 12'h004, 32'h0);
      chk({22'h0, rv[9:0]}, {24'h0, w});
   endtask
   task automatic cm(input logic [3:0] c, input int b, input logic p);
      u_mc.put(c, b[1:0], 4'h0, p, 1'b0, 16'h0, 2'b00, t);
   endtask
   task automatic nop(input int n);
      repeat (n) cm(SDBP_CMD_NOP, 0, 1'b0);
   endtask
   // activate, then leave room for the access delay
   task automatic act(input int b);
      cm(SDBP_CMD_ACT, b, 1'b0);
      nop(2);
   endtask
   // nd elements driven, the first nw expected to land
   task automatic wr(input int b, input int c, input logic p, input int nd, input int nw,
      input logic [15:0] d);
      for (int k = 0; k < nd; k++)
      begin
         u_mc.put(k == 0 ? SDBP_CMD_WR : SDBP_CMD_NOP, b[1:0], c[3:0], p, 1'b1, d + 16'(k), 2'b00, t);
         if (k < nw)
         begin
            mx[b][(c + k) % 16] = d + 16'(k);
         end
      end
   endtask
   task automatic rd(input int b, input int c, input logic p);
      u_mc.put(SDBP_CMD_RD, b[1:0], c[3:0], p, 1'b0, 16'h0, 2'b00, t0);
   endtask
   // element k is seen at edge s + rl + k + 1
   task automatic rdc(input int b, input int c, input int n, input int s);
      for (int k = 0; k < n; k++)
      begin
         if (qd.size() == 0)
         begin
            qd.push_back(16'hxxxx);
            qt.push_back(-1);
         end
         chk(qt.pop_front(), s + rl + k + 1);
         chk(qd.pop_front(), mx[b][(c + k) % 16]);
      end
   endtask
   task automatic rdx(input int b, input int c, input int n);
      rd(b, c, 1'b0);
      nop(rl + n + 2);
      rdc(b, c, n, t0);
   endtask
   task automatic fl;
      chk(qd.size(), 0);
      qd.delete();
      qt.delete();
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      #100000;
      n_mismatch++;
      close_out();
   end
   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      chk(rv, 32'h0000000a);
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, re}, 32'h1);
      chk(rv, 32'h0);
      apb(1'b1, 12'h004, 32'hffffffff);
      st(8'h00);
      // descending fills, so stray data after a burst would hit known columns
      for (int b = 0; b < 4; b++)
      begin
         act(b);
         for (int c = 12; c >= 0; c -= 4)
         begin
            wr(b, c, 1'b0, 4, 4, {b[7:0], c[7:0]});
            repeat (2) u_mc.put(SDBP_CMD_NOP, 2'b00, 4'h0, 1'b0, 1'b1, 16'hdead, 2'b00, t);
         end
      end
      st(8'h55);
      for (int b = 0; b < 4; b++)
      begin
         for (int c = 0; c < 16; c += 4)
         begin
            rdx(b, c, 4);
         end
      end
      fl();
      // masked low lane on element one, then a new write truncates
      wr(0, 0, 1'b0, 1, 1, 16'h1100);
      u_mc.put(SDBP_CMD_NOP, 2'b00, 4'h0, 1'b0, 1'b1, 16'h1101, 2'b01, t);
      mx[0][1][15:8] = 8'h11;
      wr(1, 8, 1'b0, 4, 4, 16'h1200);
      rdx(0, 0, 4);
      rdx(1, 8, 4);
      // low lane masked one edge after the read hides element one only
      rd(1, 8, 1'b0);
      u_mc.put(SDBP_CMD_NOP, 2'b00, 4'h0, 1'b0, 1'b0, 16'h0, 2'b01, t);
      nop(7);
      rdc(1, 8, 1, t0);
      chk(qt.pop_front(), t0 + rl + 2);
      chk(qd.pop_front(), 16'hxxxx);
      rdc(1, 10, 2, t0 + 2);
      // read cuts a write while stray data rides on the read edge
      wr(1, 0, 1'b0, 2, 2, 16'h1300);
      u_mc.put(SDBP_CMD_RD, 2'b01, 4'h0, 1'b0, 1'b1, 16'h1302, 2'b00, t0);
      nop(8);
      rdc(1, 0, 4, t0);
      wr(2, 0, 1'b0, 2, 2, 16'h1400);
      u_mc.put(SDBP_CMD_BST, 2'b10, 4'h0, 1'b0, 1'b1, 16'h1402, 2'b00, t);
      rdx(2, 0, 4);
      // continuous page: wrap past the last column, end by terminate
      apb(1'b1, 12'h000, 32'h0000001e);
      wr(3, 14, 1'b0, 4, 4, 16'h1500);
      u_mc.put(SDBP_CMD_BST, 2'b11, 4'h0, 1'b0, 1'b1, 16'h15ff, 2'b00, t);
      rd(3, 14, 1'b1);
      nop(3);
      cm(SDBP_CMD_BST, 3, 1'b0);
      nop(6);
      rdc(3, 14, 4, t0);
      fl();
      wr(3, 2, 1'b1, 2, 2, 16'h1600);
      cm(SDBP_CMD_BST, 3, 1'b0);
      nop(10);
      st(8'h55);
      apb(1'b1, 12'h000, 32'h0000000b);
      rl = 3;
      rdx(3, 0, 4);
      rl = 2;
      apb(1'b1, 12'h000, 32'h0000002a);
      wr(2, 8, 1'b0, 4, 1, 16'h1700);
      rdx(2, 8, 4);
      // auto precharge; a terminate inside it is ignored
      apb(1'b1, 12'h000, 32'h0000000a);
      rd(0, 0, 1'b1);
      nop(1);
      cm(SDBP_CMD_BST, 0, 1'b0);
      nop(6);
      rdc(0, 0, 4, t0);
      nop(6);
      st(8'h54);
      rd(0, 0, 1'b0);
      nop(6);
      fl();
      wr(1, 4, 1'b1, 4, 4, 16'h1800);
      nop(10);
      st(8'h50);
      // auto-precharged read interrupted by a read to another bank
      rd(2, 0, 1'b1);
      t1 = t0;
      nop(1);
      rd(3, 0, 1'b0);
      nop(8);
      rdc(2, 0, 2, t1);
      rdc(3, 0, 4, t0);
      fl();
      st(8'h40);
      // auto-precharged write interrupted by a read to another bank
      act(0);
      wr(3, 4, 1'b1, 2, 2, 16'h1900);
      rd(0, 8, 1'b0);
      nop(8);
      rdc(0, 8, 4, t0);
      nop(6);
      st(8'h01);
      act(3);
      rdx(3, 4, 4);
      cm(SDBP_CMD_PRE, 0, 1'b0);
      nop(4);
      st(8'h40);
      // auto-precharged write cut by a write to another bank
      act(1);
      wr(3, 8, 1'b1, 2, 2, 16'h1a00);
      wr(1, 0, 1'b0, 4, 4, 16'h1b00);
      nop(6);
      st(8'h04);
      // auto-precharged read cut by a write; mask two edges ahead of it
      act(0);
      rd(1, 12, 1'b1);
      u_mc.put(SDBP_CMD_NOP, 2'b00, 4'h0, 1'b0, 1'b0, 16'h0, 2'b11, t);
      nop(1);
      wr(0, 4, 1'b0, 2, 2, 16'h1c00);
      nop(6);
      rdc(1, 12, 1, t0);
      fl();
      st(8'h01);
      // single auto-precharged read at the access delay waits out row active time
      apb(1'b1, 12'h000, 32'h00000002);
      act(3);
      rd(3, 0, 1'b1);
      st(8'h41);
      nop(8);
      rdc(3, 0, 1, t0);
      st(8'h01);
      apb(1'b1, 12'h000, 32'h0000000a);
      cm(SDBP_CMD_PRE, 0, 1'b1);
      nop(4);
      st(8'h00);
      close_out();
   end
endmodule
